// ---- rtl/iqp_regs.vh ----
// Purpose: constants for the I/Q sample parallel port
// Assumes: Avalon-MM word addressing, 32-bit data
// Notes: register map below
`ifndef IQP_REGS_VH
`define IQP_REGS_VH
`define IQP_ADDR_CTRL     4'h0
`define IQP_ADDR_RXFMT    4'h1
`define IQP_ADDR_TXFMT    4'h2
`define IQP_ADDR_STATUS   4'h3
`define IQP_ADDR_TXSAMP   4'h4
// ctrl fields
`define IQP_CTRL_HALF     0
`define IQP_CTRL_DIRREG   1
`define IQP_CTRL_TRANSMIT_DIRECTION_ENABLE     2
`define IQP_CTRL_RECEIVE_DIRECTION_ENABLE     3
`define IQP_CTRL_TWOCLK   4
`define IQP_CTRL_TXCLKOUT 5
`define IQP_CTRL_CLKFREE  6
// format fields (shared by rx and tx)
`define IQP_FMT_CLKINV    0
`define IQP_FMT_IFIRST    1
`define IQP_FMT_HILO      2
`define IQP_FMT_BNRY      3
`define IQP_FMT_DDR       4
`define IQP_FMT_SINGLE    5
`define IQP_FMT_SELQ      6
`define IQP_CTRL_RST      7'h00
`define IQP_FMT_RST       7'h00
`endif

// ---- rtl/iqp_port.v ----
// Purpose: interleaved I/Q sample port, rx out and tx in, full and half duplex
// Assumes: one core clock; tx clock pin sampled and edge detected
// Notes: link rates are limited by the core clock in this model
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "iqp_regs.vh"
module iqp_port (
	input  wire        CORE_CLK_I,        // core clock
	input  wire        RESET_I,           // sync reset, high
	input  wire [3:0]  AVS_ADDRESS_I,     // word address
	input  wire        AVS_READ_I,        // read strobe
	input  wire        AVS_WRITE_I,       // write strobe
	input  wire [31:0] AVS_WRITEDATA_I,   // write data
	input  wire [3:0]  AVS_BYTEENABLE_I,  // byte enables
	output reg  [31:0] AVS_READDATA_O,    // read data
	output wire        AVS_WAITREQUEST_O, // wait request
	input  wire [11:0] RX_I_SAMPLE_I,     // rx I sample
	input  wire [11:0] RX_Q_SAMPLE_I,     // rx Q sample
	input  wire        RX_SAMPLE_VALID_I, // rx pair strobe
	output reg  [11:0] SHARED_DATA_O,     // shared bus out
	output wire        SHARED_DATA_OE_O,  // shared bus enable
	input  wire [11:0] SHARED_DATA_I,     // shared bus in
	output reg         SHARED_FLAG_O,     // shared flag out
	output wire        SHARED_FLAG_OE_O,  // shared flag enable
	input  wire        SHARED_FLAG_I,     // shared flag in
	output wire        SHARED_CLK_O,      // shared clock out
	output wire        SHARED_CLK_OE_O,   // shared clock enable
	input  wire        SHARED_CLK_I,      // shared clock in
	input  wire [11:0] TX_DATA_I,         // dedicated tx bus
	input  wire        TX_FLAG_I,         // tx channel flag
	output wire        TX_CLK_O,          // tx clock out
	output wire        TX_CLK_OE_O,       // tx clock enable
	input  wire        TX_CLK_I,          // tx clock in
	input  wire        BUS_DIR_I,         // direction pin, 1 = tx
	output reg  [11:0] TX_I_SAMPLE_O,     // assembled tx I
	output reg  [11:0] TX_Q_SAMPLE_O,     // assembled tx Q
	output reg         TX_SAMPLE_VALID_O  // tx pair strobe
);
	reg  [6:0]  ctrl_ff;
	reg  [6:0]  rxfmt_ff;
	reg  [6:0]  txfmt_ff;
	reg  [2:0]  transmit_port_clock_sync_ff;
	reg  [2:0]  shclk_sync_ff;
	reg  [1:0]  dir_sync_ff;
	reg  [12:0] txd_s1_ff;
	reg  [12:0] txd_s2_ff;
	reg  [12:0] shd_s1_ff;
	reg  [12:0] shd_s2_ff;
	reg  [11:0] rx_hold_ff;
	reg         rx_second_ff;
	reg         rx_div_ff;
	reg         rx_clk_ff;
	reg  [11:0] tx_first_ff;
	reg         tx_have_ff;
	reg  [11:0] tx_i_ff;
	reg         tx_clk_ff;
	reg  [7:0]  tx_pairs_ff;
	reg  [7:0]  rx_pairs_ff;
	reg         rx_ovf_ff;
	wire        half       = ctrl_ff[`IQP_CTRL_HALF];
	wire        two_clk    = ctrl_ff[`IQP_CTRL_TWOCLK];
	wire        transmit_port_clock_out  = ctrl_ff[`IQP_CTRL_TXCLKOUT];
	wire        clk_free   = ctrl_ff[`IQP_CTRL_CLKFREE];
	wire        rx_ddr     = rxfmt_ff[`IQP_FMT_DDR];
	wire        tx_ddr     = txfmt_ff[`IQP_FMT_DDR];
	reg         sh_rx;
	reg         sh_tx;
	wire        dir_tx_pin = dir_sync_ff[1];
	// direction decode
	always @* begin
		sh_rx = 1'b1;
		sh_tx = 1'b0;
		if (half) begin
			if (ctrl_ff[`IQP_CTRL_DIRREG]) begin
				// enable table: none = hi-z, rx wins when both set
				case ({ctrl_ff[`IQP_CTRL_TRANSMIT_DIRECTION_ENABLE], ctrl_ff[`IQP_CTRL_RECEIVE_DIRECTION_ENABLE]})
					2'b00: begin
						sh_rx = 1'b0;
						sh_tx = 1'b0;
					end
					2'b01: begin
						sh_rx = 1'b1;
						sh_tx = 1'b0;
					end
					2'b10: begin
						sh_rx = 1'b0;
						sh_tx = 1'b1;
					end
					default: begin
						sh_rx = 1'b1;
						sh_tx = 1'b0;
					end
				endcase
			end else begin
				sh_rx = ~dir_tx_pin;
				sh_tx = dir_tx_pin;
			end
		end
	end
	// avalon slave: writes take no wait, reads wait one cycle for registered data
	reg         rd_done_ff;
	reg         nxt_rd_done;
	always @* begin
		nxt_rd_done = 1'b0;
		if (AVS_READ_I && !rd_done_ff) begin
			nxt_rd_done = 1'b1;
		end
	end
	always @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			rd_done_ff <= 1'b0;
		end else begin
			rd_done_ff <= nxt_rd_done;
		end
	end
	// read data stands at the edge where waitrequest is seen low
	assign AVS_WAITREQUEST_O = AVS_READ_I & ~rd_done_ff;
	always @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			ctrl_ff  <= `IQP_CTRL_RST;
			rxfmt_ff <= `IQP_FMT_RST;
			txfmt_ff <= `IQP_FMT_RST;
		end else if (AVS_WRITE_I && AVS_BYTEENABLE_I[0]) begin
			case (AVS_ADDRESS_I)
				`IQP_ADDR_CTRL:  ctrl_ff  <= AVS_WRITEDATA_I[6:0];
				`IQP_ADDR_RXFMT: rxfmt_ff <= AVS_WRITEDATA_I[6:0];
				`IQP_ADDR_TXFMT: txfmt_ff <= AVS_WRITEDATA_I[6:0];
				default: ;
			endcase
		end
	end
	always @(posedge CORE_CLK_I) begin
		if (RESET_I)
			AVS_READDATA_O <= 32'h0;
		else if (AVS_READ_I && !rd_done_ff) begin
			case (AVS_ADDRESS_I)
				`IQP_ADDR_CTRL:   AVS_READDATA_O <= {25'h0, ctrl_ff};
				`IQP_ADDR_RXFMT:  AVS_READDATA_O <= {25'h0, rxfmt_ff};
				`IQP_ADDR_TXFMT:  AVS_READDATA_O <= {25'h0, txfmt_ff};
				`IQP_ADDR_STATUS: AVS_READDATA_O <= {13'h0, rx_ovf_ff, sh_tx, sh_rx,
					tx_pairs_ff, rx_pairs_ff};
				`IQP_ADDR_TXSAMP: AVS_READDATA_O <= {4'h0, TX_Q_SAMPLE_O, 4'h0, TX_I_SAMPLE_O};
				default:          AVS_READDATA_O <= 32'h0;
			endcase
		end
	end
	// pin synchronisers
	always @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			transmit_port_clock_sync_ff <= 3'h0;
			shclk_sync_ff <= 3'h0;
			dir_sync_ff   <= 2'h0;
			txd_s1_ff     <= 13'h0;
			txd_s2_ff     <= 13'h0;
			shd_s1_ff     <= 13'h0;
			shd_s2_ff     <= 13'h0;
		end else begin
			transmit_port_clock_sync_ff <= {transmit_port_clock_sync_ff[1:0], TX_CLK_I};
			shclk_sync_ff <= {shclk_sync_ff[1:0], SHARED_CLK_I};
			dir_sync_ff   <= {dir_sync_ff[0], BUS_DIR_I};
			txd_s1_ff     <= {TX_FLAG_I, TX_DATA_I};
			txd_s2_ff     <= txd_s1_ff;
			shd_s1_ff     <= {SHARED_FLAG_I, SHARED_DATA_I};
			shd_s2_ff     <= shd_s1_ff;
		end
	end
	// ---------------- receive side
	wire [11:0] rx_i_fmt = rxfmt_ff[`IQP_FMT_BNRY] ? RX_I_SAMPLE_I :
		{~RX_I_SAMPLE_I[11], RX_I_SAMPLE_I[10:0]};
	wire [11:0] rx_q_fmt = rxfmt_ff[`IQP_FMT_BNRY] ? RX_Q_SAMPLE_I :
		{~RX_Q_SAMPLE_I[11], RX_Q_SAMPLE_I[10:0]};
	wire        ifirst   = rxfmt_ff[`IQP_FMT_IFIRST];
	wire        i_hi     = rxfmt_ff[`IQP_FMT_HILO];
	wire        single   = rxfmt_ff[`IQP_FMT_SINGLE];
	wire        sel_q    = rxfmt_ff[`IQP_FMT_SELQ];
	wire        rx_run   = ~half | sh_rx;
	// word launch: one word per clock period (sdr) or per half period (ddr)
	wire        rx_launch = rx_ddr ? 1'b1 : rx_div_ff;
	always @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			SHARED_DATA_O <= 12'h0;
			SHARED_FLAG_O <= 1'b0;
			rx_hold_ff    <= 12'h0;
			rx_second_ff  <= 1'b0;
			rx_div_ff     <= 1'b0;
			rx_clk_ff     <= 1'b0;
			rx_pairs_ff   <= 8'h0;
			rx_ovf_ff     <= 1'b0;
		end else if (!rx_run) begin
			rx_second_ff <= 1'b0;
			rx_div_ff    <= 1'b0;
			rx_clk_ff    <= 1'b0;
		end else begin
			rx_div_ff <= ~rx_div_ff;
			// data changes with rising clock; ddr toggles every word
			if (rx_ddr) begin
				// single converter has no pair phase: toggle per word
				if (single) begin
					rx_clk_ff <= ~rx_clk_ff;
				end else begin
					rx_clk_ff <= rx_second_ff ? 1'b0 : 1'b1;
				end
			end else begin
				rx_clk_ff <= rx_launch;
			end
			if (rx_launch) begin
				if (single) begin
					SHARED_DATA_O <= sel_q ? rx_q_fmt : rx_i_fmt;
					SHARED_FLAG_O <= sel_q ^ i_hi;
				end else if (!rx_second_ff) begin
					if (RX_SAMPLE_VALID_I) begin
						SHARED_DATA_O <= ifirst ? rx_i_fmt : rx_q_fmt;
						rx_hold_ff    <= ifirst ? rx_q_fmt : rx_i_fmt;
						SHARED_FLAG_O <= ifirst ~^ i_hi;
						rx_second_ff  <= 1'b1;
						rx_pairs_ff   <= rx_pairs_ff + 8'h01;
					end
				end else begin
					SHARED_DATA_O <= rx_hold_ff;
					SHARED_FLAG_O <= ifirst ^ i_hi;
					rx_second_ff  <= 1'b0;
					rx_ovf_ff     <= rx_ovf_ff | RX_SAMPLE_VALID_I;
				end
			end
		end
	end
	// rx clock: inversion moves launch to falling edge
	wire rx_clk_pin = rx_clk_ff ^ rxfmt_ff[`IQP_FMT_CLKINV];
	// ---------------- transmit side
	wire        hd_tx_path = half & sh_tx;
	wire        tx_port_on = ~half;
	wire        use_shclk  = half & ~two_clk & ~transmit_port_clock_out;
	wire [2:0]  ck         = use_shclk ? shclk_sync_ff : transmit_port_clock_sync_ff;
	wire        ck_rise    = ck[1] & ~ck[2];
	wire        ck_fall    = ~ck[1] & ck[2];
	wire        own_rise   = transmit_port_clock_out & ~tx_ddr & tx_clk_ff & ~rx_div_ff;
	wire [12:0] tx_word    = hd_tx_path ? shd_s2_ff : txd_s2_ff;
	wire        tx_active  = tx_port_on | hd_tx_path;
	// ddr ignores the flag; clock edge names the channel
	wire        ext_clk    = tx_ddr | ~transmit_port_clock_out;
	wire        cap        = tx_active & (tx_ddr ? (ck_rise | ck_fall) :
		(ext_clk ? ck_rise : own_rise));
	wire        tx_flag    = tx_ddr ? ck_rise : tx_word[12];
	wire        is_i       = tx_flag ~^ txfmt_ff[`IQP_FMT_HILO];
	wire        is_first   = is_i ~^ txfmt_ff[`IQP_FMT_IFIRST];
	wire [11:0] tx_val     = txfmt_ff[`IQP_FMT_BNRY] ? tx_word[11:0] :
		{~tx_word[11], tx_word[10:0]};
	// a new format drops a half-built pair so it cannot pair across formats
	wire        tx_fmt_wr  = AVS_WRITE_I & AVS_BYTEENABLE_I[0] &
		(AVS_ADDRESS_I == `IQP_ADDR_TXFMT);
	always @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			tx_first_ff       <= 12'h0;
			tx_have_ff        <= 1'b0;
			tx_i_ff           <= 12'h0;
			tx_clk_ff         <= 1'b0;
			tx_pairs_ff       <= 8'h0;
			TX_I_SAMPLE_O     <= 12'h0;
			TX_Q_SAMPLE_O     <= 12'h0;
			TX_SAMPLE_VALID_O <= 1'b0;
		end else begin
			TX_SAMPLE_VALID_O <= 1'b0;
			tx_clk_ff         <= (tx_active & transmit_port_clock_out & ~tx_ddr) ? ~tx_clk_ff : 1'b0;
			if (!tx_active || tx_fmt_wr)
				tx_have_ff <= 1'b0;
			else if (cap) begin
				if (is_first) begin
					tx_first_ff <= tx_val;
					tx_i_ff     <= is_i ? tx_val : 12'h0;
					tx_have_ff  <= 1'b1;
				end else if (tx_have_ff) begin
					TX_I_SAMPLE_O     <= is_i ? tx_val : tx_first_ff;
					TX_Q_SAMPLE_O     <= is_i ? tx_first_ff : tx_val;
					TX_SAMPLE_VALID_O <= 1'b1;
					tx_have_ff        <= 1'b0;
					tx_pairs_ff       <= tx_pairs_ff + 8'h01;
				end
			end
		end
	end
	// ---------------- pins
	reg         sh_clk_oe;
	reg         sh_clk_val;
	reg         tx_clk_oe;
	wire        sh_tx_clk_src = half & sh_tx & ~two_clk & transmit_port_clock_out & ~tx_ddr;
	always @* begin
		sh_clk_oe  = 1'b0;
		sh_clk_val = 1'b0;
		tx_clk_oe  = 1'b0;
		// shared clock: rx clock when rx drives, tx clock in one-clock tx mode
		if (rx_run) begin
			sh_clk_oe  = clk_free | ~half | sh_rx;
			sh_clk_val = rx_clk_pin;
		end else if (sh_tx_clk_src) begin
			sh_clk_oe  = 1'b1;
			sh_clk_val = tx_clk_ff;
		end
		// dedicated tx clock: sourced, sdr, not folded onto the shared pin
		if (transmit_port_clock_out && !tx_ddr && (!half || two_clk)) begin
			tx_clk_oe = tx_port_on | hd_tx_path | clk_free;
		end
	end
	assign SHARED_DATA_OE_O = rx_run;
	assign SHARED_FLAG_OE_O = rx_run;
	assign SHARED_CLK_OE_O  = sh_clk_oe;
	assign SHARED_CLK_O     = sh_clk_val;
	assign TX_CLK_OE_O      = tx_clk_oe;
	assign TX_CLK_O         = tx_clk_oe & tx_clk_ff;
	// 200 MSPS target applies to the silicon port; here bounded by core clock
endmodule // iqp_port

// ---- test/iqp_chk.sv ----
// Purpose: port checker for iqp_port
// Assumes: config shadowed from Avalon writes
// Notes: checks wait until config has settled
`timescale 1ns/1ps
module iqp_chk (
	input wire        CORE_CLK_I,       // clock
	input wire        RESET_I,          // reset
	input wire [3:0]  AVS_ADDRESS_I,    // address
	input wire        AVS_WRITE_I,      // write
	input wire [31:0] AVS_WRITEDATA_I,  // write data
	input wire [3:0]  AVS_BYTEENABLE_I, // lanes
	input wire [11:0] SHARED_DATA_O,    // shared data
	input wire        SHARED_DATA_OE_O, // shared enable
	input wire        SHARED_CLK_O,     // shared clock
	input wire        TX_CLK_OE_O,      // tx clock enable
	input wire        BUS_DIR_I         // direction pin
);
	reg  [20:0] cfg_ff; // tx fmt, rx fmt, ctrl
	reg  [2:0]  age_ff; // cycles since a write
	wire        wr = AVS_WRITE_I && AVS_BYTEENABLE_I[0];
	wire        st = age_ff == 3'h7;
	always @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			cfg_ff <= 21'h000000;
			age_ff <= 3'h0;
		end else begin
			if (wr && AVS_ADDRESS_I < 4'h3)
				cfg_ff[AVS_ADDRESS_I * 7 +: 7] <= AVS_WRITEDATA_I[6:0];
			age_ff <= wr ? 3'h0 : age_ff + {2'h0, !st};
		end
	end
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);
	AST_FULL_RX: assert property (st && !cfg_ff[0] |-> SHARED_DATA_OE_O)
		else $error("shared bus idle in full duplex");
	AST_REG_HIZ: assert property (st && cfg_ff[3:0] == 4'h3 |-> !SHARED_DATA_OE_O)
		else $error("shared bus driven with enables low");
	AST_REG_RX: assert property (st && cfg_ff[1:0] == 2'h3 && cfg_ff[3] |-> SHARED_DATA_OE_O)
		else $error("shared bus not in receive");
	AST_REG_TX: assert property (st && cfg_ff[3:0] == 4'h7 |-> !SHARED_DATA_OE_O)
		else $error("shared bus driven in transmit");
	AST_PIN_TX: assert property ((st && cfg_ff[1:0] == 2'h1 && BUS_DIR_I) [*5] |-> !SHARED_DATA_OE_O)
		else $error("pin transmit left bus driven");
	AST_RX_RISE: assert property (st && cfg_ff[11:7] == 5'h0 && !cfg_ff[0] && $changed(SHARED_DATA_O) |-> $rose(SHARED_CLK_O))
		else $error("rx word not on rising clock");
	AST_RX_INV: assert property (st && cfg_ff[11:7] == 5'h1 && !cfg_ff[0] && $changed(SHARED_DATA_O) |-> $fell(SHARED_CLK_O))
		else $error("inverted rx word not on falling clock");
	AST_RX_DDR: assert property (st && cfg_ff[11] && !cfg_ff[0] && $changed(SHARED_DATA_O) |-> $changed(SHARED_CLK_O))
		else $error("ddr word without clock edge");
	AST_TRANSMIT_PORT_CLOCK_IN: assert property (st && (!cfg_ff[5] || cfg_ff[18]) |-> !TX_CLK_OE_O)
		else $error("tx clock sourced when it is an input");
endmodule // iqp_chk
bind iqp_port iqp_chk u_chk (.*);

// ---- test/iqp_bbp.sv ----
// Purpose: baseband side sending tx words on its own link clock
// Assumes: 800 ns link period, eight core cycles
// Notes: lines show the inverse word between frames
`timescale 1ns/1ps
module iqp_bbp (
	input  wire        clk_i,  // core clock
	output reg         lclk_o, // link clock
	output reg  [11:0] data_o, // tx word
	output reg         flag_o  // channel flag
);
	initial begin
		lclk_o = 1'b0;
		data_o = 12'h000;
		flag_o = 1'b0;
	end
	task automatic put(input [11:0] d, input f, input c);
		begin
			data_o <= d;
			flag_o <= f;
			lclk_o <= !c;
			repeat (4) @(posedge clk_i);
			lclk_o <= c;
			repeat (4) @(posedge clk_i);
		end
	endtask
	task automatic send(input [11:0] a, input [11:0] b, input fa, input ddr);
		begin
			put(a, fa, 1'b1);
			put(b, !fa, !ddr);
			data_o <= ~b;
			flag_o <= fa;
			lclk_o <= 1'b0;
		end
	endtask
endmodule // iqp_bbp

// ---- test/tb.sv ----
// Purpose: self-checking bench for iqp_port
// Assumes: 10 MHz core clock, link clock from iqp_bbp
// Notes: rx pair offered all run long
`timescale 1ns/1ps
module tb;
	localparam [11:0] VI = 12'h3a5;
	localparam [11:0] VQ = 12'h5c6;
	logic        clk, rst, rd, wr, rx_v, dir, half, pc, f1;
	logic [3:0]  adr;
	logic [31:0] wd;
	logic [12:0] lw;
	logic [11:0] iv, qv;
	logic [31:0] rv;
	wire  [31:0] rdat;
	wire  [11:0] sd_o, p_d, ti, tq;
	wire         wreq, sd_oe, sf_o, sf_oe, sc_o, sc_oe, tc_oe, tv, p_f, p_c;
	integer      n_errors = 0, checks = 0, nl = 0, m = 0, k;
	iqp_bbp bbp (.clk_i(clk), .lclk_o(p_c), .data_o(p_d), .flag_o(p_f));
	iqp_port dut (
		.CORE_CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf),
		.AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .RX_I_SAMPLE_I(VI),
		.RX_Q_SAMPLE_I(VQ), .RX_SAMPLE_VALID_I(rx_v), .SHARED_DATA_O(sd_o),
		.SHARED_DATA_OE_O(sd_oe), .SHARED_DATA_I(sd_oe ? sd_o : p_d), .SHARED_FLAG_O(sf_o),
		.SHARED_FLAG_OE_O(sf_oe), .SHARED_FLAG_I(sf_oe ? sf_o : p_f), .SHARED_CLK_O(sc_o),
		.SHARED_CLK_OE_O(sc_oe), .SHARED_CLK_I(sc_oe ? sc_o : p_c), .TX_DATA_I(half ? ~p_d : p_d),
		.TX_FLAG_I(p_f), .TX_CLK_O(), .TX_CLK_OE_O(tc_oe), .TX_CLK_I(p_c), .BUS_DIR_I(dir),
		.TX_I_SAMPLE_O(ti), .TX_Q_SAMPLE_O(tq), .TX_SAMPLE_VALID_O(tv));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// word launch monitor, any clock edge counts in ddr
	always @(negedge clk) begin
		if (sc_o !== pc && (m[3] || sc_o === 1'b1)) begin
			lw = {sf_o, sd_o};
			nl = nl + 1;
		end
		pc = sc_o;
	end
	task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("wrong value %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task automatic bus(input [3:0] a, input w, input [31:0] d);
		begin
			adr <= a;
			wd <= d;
			wr <= w;
			rd <= !w;
			@(posedge clk);
			while (wreq !== 1'b0)
				@(posedge clk);
			rv = rdat;
			wr <= 1'b0;
			rd <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic launch;
		integer k0, n;
		begin
			k0 = nl;
			for (n = 0; nl == k0 && n < 40; n++)
				@(posedge clk);
		end
	endtask
	task automatic txp(input fi, input hl, input bn, input ddr);
		integer n;
		begin
			n = 0;
			fork
				begin
					bbp.send(fi ? VI : VQ, fi ? VQ : VI, (fi ~^ hl) ^ ddr, ddr);
					// ddr pair may start on either edge: offer it twice
					if (ddr) begin
						@(posedge clk);
						bbp.send(fi ? VI : VQ, fi ? VQ : VI, (fi ~^ hl) ^ ddr, ddr);
					end
				end
				begin
					while (tv !== 1'b1 && n < 80) begin
						@(negedge clk);
						n = n + 1;
					end
					chk("tx pair strobe", tv, 32'h1);
					chk("tx pair", {ti, tq}, {VI ^ {!bn, 11'h0}, VQ ^ {!bn, 11'h0}});
				end
			join
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d n_errors %0d", checks, n_errors);
			if (n_errors == 0 && checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	// whole run needs well under 5000 cycles
	initial begin
		#3000000;
		n_errors = n_errors + 1;
		complete_run;
	end
	initial begin
		{rst, rd, wr, rx_v, dir, half, adr, wd} = 42'h200_0000_0000;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rx_v <= 1'b1;
		for (k = 0; k < 4; k++) begin
			bus(k == 3 ? 4'hf : k[3:0], 1'b0, 32'h0);
			chk("reset register", rv, 32'h0);
		end
		for (m = 0; m < 16; m++) begin
			bus(4'h1, 1'b1, {27'h0, m[3:0], 1'b0});
			iv = m[2] ? VI : VI ^ 12'h800;
			qv = m[2] ? VQ : VQ ^ 12'h800;
			f1 = m[0] ~^ m[1];
			launch;
			for (k = 0; lw[12] !== f1 && k < 6; k++)
				launch;
			chk("rx first", lw, {f1, m[0] ? iv : qv});
			launch;
			chk("rx second", lw, {!f1, m[0] ? qv : iv});
		end
		bus(4'h1, 1'b1, 32'h1);
		repeat (12) @(posedge clk);
		for (m = 0; m < 16; m++) begin
			bus(4'h2, 1'b1, {27'h0, m[3:0], 1'b0});
			txp(m[3] ? m[1] : m[0], m[1], m[2], m[3]);
		end
		bus(4'h2, 1'b0, 32'h0);
		chk("tx format readback", rv, 32'h1e);
		for (k = 0; k < 6; k++) begin
			dir <= k == 4;
			bus(4'h0, 1'b1, k < 4 ? 32'h3 | k << 2 : 32'h1);
			repeat (8) @(posedge clk);
			chk("shared oe", sd_oe, k < 4 ? (k >> 1) & 1 : k == 5);
		end
		half <= 1'b1;
		bus(4'h0, 1'b1, 32'h7);
		bus(4'h2, 1'b1, 32'h6);
		txp(1'b1, 1'b1, 1'b0, 1'b0);
		half <= 1'b0;
		bus(4'h0, 1'b1, 32'h20);
		repeat (8) @(posedge clk);
		chk("tx clock oe", tc_oe, 32'h1);
		complete_run;
	end
endmodule // tb
